/* File: hdl/cmbt_pkg.sv */
`default_nettype none

package cmbt_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_ADDR   = 8'h04;
  localparam logic [7:0]  OFS_CMD    = 8'h08;
  localparam logic [7:0]  OFS_STAT   = 8'h0c;
  localparam logic [7:0]  OFS_MASK   = 8'h10;
  localparam logic [2:0]  OFS_BUF_HI = 3'h1;   // paddr[7:5] of buffer words 0x20..0x3c

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_ENH   = 0;
  localparam int          CMD_KIND   = 0;      // [2:0]
  localparam int          CMD_LEN    = 4;      // [6:4] words minus one
  localparam int          CMD_SIZE   = 8;      // [9:8] standard single size
  localparam int          CMD_CACHE  = 12;
  localparam int          CMD_ABSENT = 13;
  localparam int          STAT_BUSY  = 0;
  localparam int          STAT_LOCK  = 1;
  localparam int          STAT_ERR   = 2;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] ADDR_RST   = 32'h0000_0000;
  localparam logic [31:0] MASK_RST   = 32'hffff_ffff;
  localparam logic [31:0] CMD_RST    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // bus encodings and counts
  // ----------------------------------------------------------------
  localparam logic [1:0]  SIZE_WORD  = 2'h2;
  localparam logic [2:0]  LINE_LM1   = 3'h7;   // eight words minus one
  localparam logic [3:0]  LANES_ALL  = 4'hf;

  typedef enum logic [2:0] {
    K_RD    = 3'h0,
    K_WR    = 3'h1,
    K_FILL  = 3'h2,
    K_WBST  = 3'h3,
    K_SWAP  = 3'h4,
    K_XLAT  = 3'h5
  } cmbt_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOAD = 2'h1,
    ST_ANN  = 2'h3,
    ST_DATA = 2'h2
  } cmbt_state_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } cmbt_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cmbt_apb_rsp_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0]  access_size_pins;
    logic        read_not_write_n;
    logic        line_fill_flag;
    logic        lock;
    logic        cycle_type_idle_n;
    logic [1:0]  lane_select_outputs;
  } cmbt_pins_t;

endpackage : cmbt_pkg

`default_nettype wire

/* File: hdl/cmbt_word_buf.sv */
`timescale 1ns/1ns
`default_nettype none

module cmbt_word_buf (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // write port
  input  wire logic        we,
  input  wire logic [2:0]  widx,
  input  wire logic [31:0] wdata,
  // read port
  input  wire logic [2:0]  ridx,
  output logic [31:0]      rdata_q
);

  logic [31:0] mem [8];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // array write
  always_ff @(posedge clk) begin
    if (we) begin
      mem[widx] <= wdata;
    end
  end

  // registered read, one cycle after the index
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= mem[ridx];
    end
  end

endmodule : cmbt_word_buf

`default_nettype wire

/* File: hdl/cmbt_bus_engine.sv */
`timescale 1ns/1ns
`default_nettype none

// Contract
// - idle gaps hold address, direction, lanes
// - any idle gap between accesses allowed
// - uncached read, unbuffered write: single access
// - translation fetches are single uncached reads
// - enhanced buffered writes start nonsequential
// - merged subblock writes: sequential run, masks
// - line fill is eight words, any start
// - fill starts critical word or word zero
// - line fill flag on every fill access
// - uncached swap: read then write, nonsequential
// - lock rises at read, falls after write
// - lock held across swap idle gap
// - cached swap: no lock, fill if absent
// - stall low adds one whole cycle
// - read bursts only for eight-word fills
// - standard write bursts from merged stores
// - enhanced write bursts 2,3,4,8 words
// - 32-byte store burst: flag, all lanes
// - no burst crosses 32-byte boundary
// - fill start offset by mode setting
// - standard write burst start offsets, full bytes
// - enhanced end words write one byte minimum
// - cycle type pin announces next cycle
// - enhanced byte mask on address, size pins
// - standard size pins and byte address
module cmbt_bus_engine (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    nrst,
  // apb register slave
  input  wire cmbt_pkg::cmbt_apb_req_t apb_req,
  output var  cmbt_pkg::cmbt_apb_rsp_t apb_rsp,
  // memory bus
  output var  cmbt_pkg::cmbt_pins_t    pins,
  output logic [31:0]                  data_o,
  output logic                         data_oe,
  input  wire logic [31:0]             data_i,
  input  wire logic                    stall_request_n
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // legal burst start word for a length
  function automatic logic burst_ok(input logic [2:0] lm1, input logic [2:0] sw);
    logic ok;
    ok = 1'b0;
    unique case (lm1)
      3'h0:    ok = 1'b1;
      3'h1:    ok = (sw[1:0] != 2'h3);
      3'h2:    ok = !sw[1];
      3'h3:    ok = (sw[1:0] == 2'h0);
      3'h7:    ok = (sw == 3'h0);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : burst_ok

  // active-high lane nibble of word i
  function automatic logic [3:0] nib(input logic [31:0] m, input logic [2:0] i);
    return m[{i, 2'b00} +: 4];
  endfunction : nib

  // line word carried by the n-th transfer
  function automatic logic [2:0] word_at(input cmbt_pkg::cmbt_kind_t k, input logic enh,
                                         input logic [2:0] sw, input logic [2:0] n);
    if (k == cmbt_pkg::K_FILL && enh) begin
      return {sw[2] ^ n[2], 2'(sw[1:0] + n[1:0])};
    end else if (k == cmbt_pkg::K_FILL) begin
      return n;
    end
    return 3'(sw + n);
  endfunction : word_at

  // buffer slot of the n-th transfer
  function automatic logic [2:0] buf_idx(input cmbt_pkg::cmbt_kind_t k, input logic enh,
                                         input logic [2:0] sw, input logic [2:0] n,
                                         input logic swr);
    if (k == cmbt_pkg::K_FILL) begin
      return word_at(k, enh, sw, n);
    end else if (k == cmbt_pkg::K_WBST) begin
      return n;
    end
    return {2'b00, swr};
  endfunction : buf_idx

  // direction of the current access
  function automatic logic is_wr(input cmbt_pkg::cmbt_kind_t k, input logic swr);
    return (k == cmbt_pkg::K_WR) || (k == cmbt_pkg::K_WBST) || (k == cmbt_pkg::K_SWAP && swr);
  endfunction : is_wr

  // address-timed pins of the n-th transfer
  function automatic cmbt_pkg::cmbt_pins_t mk_pins(input cmbt_pkg::cmbt_kind_t k, input logic enh,
                                                   input logic [31:0] base, input logic [2:0] n,
                                                   input logic [2:0] lm1, input logic [31:0] m,
                                                   input logic [1:0] sz, input logic swr);
    cmbt_pkg::cmbt_pins_t p;
    logic                 single;
    logic [3:0]           ln;
    p      = '0;
    single = (k == cmbt_pkg::K_RD) || (k == cmbt_pkg::K_WR) || (k == cmbt_pkg::K_XLAT);
    ln     = cmbt_pkg::LANES_ALL;
    if (k == cmbt_pkg::K_WR) begin
      ln = nib(m, 3'h0);
    end else if (k == cmbt_pkg::K_WBST && lm1 != cmbt_pkg::LINE_LM1) begin
      ln = nib(m, n);
    end
    p.read_not_write_n = is_wr(k, swr);
    p.line_fill_flag   = (k == cmbt_pkg::K_FILL) ||
                         (k == cmbt_pkg::K_WBST && lm1 == cmbt_pkg::LINE_LM1);
    p.addr[31:2]       = single ? base[31:2] : {base[31:5], word_at(k, enh, base[4:2], n)};
    if (enh) begin
      p.addr[1:0]           = ~ln[3:2];
      p.access_size_pins    = ~ln[1:0];
      p.lane_select_outputs = 2'h0;
    end else begin
      p.addr[1:0]           = single ? base[1:0] : 2'h0;
      p.access_size_pins    = single ? sz : cmbt_pkg::SIZE_WORD;
      p.lane_select_outputs = p.addr[1:0];
    end
    p.cycle_type_idle_n = 1'b1;
    return p;
  endfunction : mk_pins

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  cmbt_pkg::cmbt_state_t state_q;
  cmbt_pkg::cmbt_kind_t  kind_q;
  cmbt_pkg::cmbt_kind_t  cmd_kind;
  logic [31:0]           ctrl_q;
  logic [31:0]           addr_q;
  logic [31:0]           mask_q;
  logic [31:0]           cmd_q;
  logic                  err_q;
  logic [2:0]            lm1_q;
  logic [2:0]            cnt_q;
  logic                  swr_q;
  logic [1:0]            size_q;
  logic [31:0]           prdata_q;
  logic [31:0]           buf_rdata;
  logic                  enh;
  logic                  acc;
  logic                  wr_acc;
  logic                  hit_buf;
  logic                  hit_reg;
  logic                  idle;
  logic                  cmd_wr;
  logic                  cmd_legal;
  logic                  cmd_noop;
  logic [2:0]            cmd_lm1;
  logic                  adv;
  logic                  last;
  logic [2:0]            cnt_nx;
  logic                  buf_we;
  logic [2:0]            buf_widx;
  logic [31:0]           buf_wdata;
  logic [2:0]            buf_ridx;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // access phase, map hits, engine idle
  assign enh     = ctrl_q[cmbt_pkg::CTRL_ENH];
  assign acc     = apb_req.psel && apb_req.penable;
  assign wr_acc  = acc && apb_req.pwrite;
  assign idle    = (state_q == cmbt_pkg::ST_IDLE);
  assign hit_buf = (apb_req.paddr[31:8] == 24'h00_0000) && (apb_req.paddr[1:0] == 2'h0) &&
                   (apb_req.paddr[7:5] == cmbt_pkg::OFS_BUF_HI);
  assign hit_reg = (apb_req.paddr[31:8] == 24'h00_0000) &&
                   ((apb_req.paddr[7:0] == cmbt_pkg::OFS_CTRL) ||
                    (apb_req.paddr[7:0] == cmbt_pkg::OFS_ADDR) ||
                    (apb_req.paddr[7:0] == cmbt_pkg::OFS_CMD)  ||
                    (apb_req.paddr[7:0] == cmbt_pkg::OFS_STAT) ||
                    (apb_req.paddr[7:0] == cmbt_pkg::OFS_MASK));

  // zero-wait answer, error on unmapped address
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = acc && !(hit_buf || hit_reg);
  assign apb_rsp.prdata  = hit_buf ? buf_rdata : prdata_q;

  // register read data captured in setup phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_req.psel && !apb_req.penable) begin
      unique case (apb_req.paddr[7:0])
        cmbt_pkg::OFS_CTRL: prdata_q <= ctrl_q;
        cmbt_pkg::OFS_ADDR: prdata_q <= addr_q;
        cmbt_pkg::OFS_CMD:  prdata_q <= cmd_q;
        cmbt_pkg::OFS_MASK: prdata_q <= mask_q;
        cmbt_pkg::OFS_STAT: prdata_q <= {29'h0, err_q, pins.lock, !idle};
        default:            prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // configuration held stable while a transaction runs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= cmbt_pkg::CTRL_RST;
      addr_q <= cmbt_pkg::ADDR_RST;
      mask_q <= cmbt_pkg::MASK_RST;
      cmd_q  <= cmbt_pkg::CMD_RST;
    end else if (wr_acc && idle && apb_req.paddr[31:8] == 24'h00_0000) begin
      unique case (apb_req.paddr[7:0])
        cmbt_pkg::OFS_CTRL: ctrl_q <= {31'h0, apb_req.pwdata[cmbt_pkg::CTRL_ENH]};
        cmbt_pkg::OFS_ADDR: addr_q <= apb_req.pwdata;
        cmbt_pkg::OFS_MASK: mask_q <= apb_req.pwdata;
        cmbt_pkg::OFS_CMD:  cmd_q  <= apb_req.pwdata;
        default:            ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command check
  // ----------------------------------------------------------------
  // decode and legality of a command word
  always_comb begin
    cmd_wr    = wr_acc && idle && (apb_req.paddr[31:0] == {24'h0, cmbt_pkg::OFS_CMD});
    cmd_kind  = cmbt_pkg::cmbt_kind_t'(apb_req.pwdata[cmbt_pkg::CMD_KIND +: 3]);
    cmd_noop  = (cmd_kind == cmbt_pkg::K_SWAP) && apb_req.pwdata[cmbt_pkg::CMD_CACHE] &&
                !apb_req.pwdata[cmbt_pkg::CMD_ABSENT];
    cmd_lm1   = 3'h0;
    cmd_legal = 1'b1;
    unique case (cmd_kind)
      cmbt_pkg::K_FILL: cmd_lm1 = cmbt_pkg::LINE_LM1;
      cmbt_pkg::K_WBST: begin
        cmd_lm1   = apb_req.pwdata[cmbt_pkg::CMD_LEN +: 3];
        cmd_legal = burst_ok(cmd_lm1, addr_q[4:2]) && cmd_lm1 != 3'h0 &&
                    (!enh || cmd_lm1 == cmbt_pkg::LINE_LM1 ||
                     (nib(mask_q, 3'h0) != 4'h0 && nib(mask_q, cmd_lm1) != 4'h0));
      end
      cmbt_pkg::K_WR:   cmd_legal = !enh || nib(mask_q, 3'h0) != 4'h0;
      cmbt_pkg::K_SWAP: cmd_lm1 = 3'h0;
      cmbt_pkg::K_RD, cmbt_pkg::K_XLAT: cmd_lm1 = 3'h0;
      default:          cmd_legal = 1'b0;
    endcase
  end

  // error flag follows the latest command
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_q <= 1'b0;
    end else if (cmd_wr) begin
      err_q <= !cmd_legal;
    end
  end

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  // stall is sampled at the edge that would end a data cycle
  assign adv    = (state_q == cmbt_pkg::ST_DATA) && stall_request_n;
  assign last   = (cnt_q == lm1_q);
  assign cnt_nx = 3'(cnt_q + 3'h1);

  // state, command latch and word counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= cmbt_pkg::ST_IDLE;
      kind_q  <= cmbt_pkg::K_RD;
      lm1_q   <= 3'h0;
      cnt_q   <= 3'h0;
      swr_q   <= 1'b0;
      size_q  <= cmbt_pkg::SIZE_WORD;
    end else begin
      unique case (state_q)
        cmbt_pkg::ST_IDLE: begin
          if (cmd_wr && cmd_legal && !cmd_noop) begin
            state_q <= cmbt_pkg::ST_LOAD;
            kind_q  <= (cmd_kind == cmbt_pkg::K_SWAP && apb_req.pwdata[cmbt_pkg::CMD_CACHE]) ?
                       cmbt_pkg::K_FILL : cmd_kind;
            lm1_q   <= (cmd_kind == cmbt_pkg::K_SWAP && apb_req.pwdata[cmbt_pkg::CMD_CACHE]) ?
                       cmbt_pkg::LINE_LM1 : cmd_lm1;
            size_q  <= apb_req.pwdata[cmbt_pkg::CMD_SIZE +: 2];
            cnt_q   <= 3'h0;
            swr_q   <= 1'b0;
          end
        end
        cmbt_pkg::ST_LOAD: state_q <= cmbt_pkg::ST_ANN;
        cmbt_pkg::ST_ANN:  state_q <= cmbt_pkg::ST_DATA;
        cmbt_pkg::ST_DATA: begin
          if (adv && last && kind_q == cmbt_pkg::K_SWAP && !swr_q) begin
            swr_q   <= 1'b1;
            state_q <= cmbt_pkg::ST_ANN;
          end else if (adv && last) begin
            state_q <= cmbt_pkg::ST_IDLE;
          end else if (adv) begin
            cnt_q   <= cnt_nx;
          end
        end
      endcase
    end
  end

  // address-timed pins and cycle type
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pins <= '{addr: 32'h0, access_size_pins: cmbt_pkg::SIZE_WORD, read_not_write_n: 1'b0,
                line_fill_flag: 1'b0, lock: 1'b0, cycle_type_idle_n: 1'b1,
                lane_select_outputs: 2'h0};
    end else begin
      unique case (state_q)
        cmbt_pkg::ST_IDLE: ;
        cmbt_pkg::ST_LOAD: begin
          pins      <= mk_pins(kind_q, enh, addr_q, 3'h0, lm1_q, mask_q, size_q, 1'b0);
          pins.lock <= (kind_q == cmbt_pkg::K_SWAP);
          pins.cycle_type_idle_n <= 1'b0;
        end
        cmbt_pkg::ST_ANN: pins.cycle_type_idle_n <= (lm1_q == 3'h0);
        cmbt_pkg::ST_DATA: begin
          if (adv && last && kind_q == cmbt_pkg::K_SWAP && !swr_q) begin
            pins      <= mk_pins(kind_q, enh, addr_q, 3'h0, lm1_q, mask_q, size_q, 1'b1);
            pins.lock <= 1'b1;
            pins.cycle_type_idle_n <= 1'b0;
          end else if (adv && last) begin
            pins.lock              <= 1'b0;
            pins.cycle_type_idle_n <= 1'b1;
          end else if (adv) begin
            pins      <= mk_pins(kind_q, enh, addr_q, cnt_nx, lm1_q, mask_q, size_q, swr_q);
            pins.lock <= pins.lock;
            pins.cycle_type_idle_n <= (cnt_nx == lm1_q);
          end
        end
      endcase
    end
  end

  // data bus drive enable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_oe <= 1'b0;
    end else if (state_q == cmbt_pkg::ST_ANN) begin
      data_oe <= is_wr(kind_q, swr_q);
    end else if (adv && last) begin
      data_oe <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // word buffer
  // ----------------------------------------------------------------
  // read data captured at the end of an unstalled data cycle
  always_comb begin
    buf_we    = 1'b0;
    buf_widx  = apb_req.paddr[4:2];
    buf_wdata = apb_req.pwdata;
    if (adv && !is_wr(kind_q, swr_q)) begin
      buf_we    = 1'b1;
      buf_widx  = buf_idx(kind_q, enh, addr_q[4:2], cnt_q, swr_q);
      buf_wdata = data_i;
    end else if (wr_acc && idle && hit_buf) begin
      buf_we    = 1'b1;
    end
  end

  // next word prefetched so write data is on time
  always_comb begin
    buf_ridx = apb_req.paddr[4:2];
    if (adv && !last) begin
      buf_ridx = buf_idx(kind_q, enh, addr_q[4:2], cnt_nx, swr_q);
    end else if (!idle && state_q != cmbt_pkg::ST_LOAD) begin
      buf_ridx = buf_idx(kind_q, enh, addr_q[4:2], cnt_q, swr_q);
    end
  end

  cmbt_word_buf u_buf (
    .clk     (clk),
    .nrst    (nrst),
    .we      (buf_we),
    .widx    (buf_widx),
    .wdata   (buf_wdata),
    .ridx    (buf_ridx),
    .rdata_q (buf_rdata)
  );

  // write data straight from the buffer register
  assign data_o = buf_rdata;

endmodule : cmbt_bus_engine

`default_nettype wire

/* File: verification/cmbt_bus_engine_props.sv */
`timescale 1ns/1ns
`default_nettype none

module cmbt_bus_props (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    nrst,
  // watched ports
  input wire cmbt_pkg::cmbt_apb_req_t apb_req,
  input wire cmbt_pkg::cmbt_apb_rsp_t apb_rsp,
  input wire cmbt_pkg::cmbt_pins_t    pins,
  input wire logic [31:0]             data_o,
  input wire logic                    data_oe,
  input wire logic [31:0]             data_i,
  input wire logic                    stall_request_n
);
  logic       dc_q;
  logic [3:0] wc_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // data cycle tracker and unstalled word counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dc_q <= 1'b0;
      wc_q <= 4'h0;
    end else begin
      dc_q <= !pins.cycle_type_idle_n || (dc_q && !stall_request_n);
      wc_q <= !dc_q ? 4'h0 : wc_q + {3'h0, stall_request_n};
    end
  end

  AST_IDLE_HOLD: assert property (pins.cycle_type_idle_n && $past(pins.cycle_type_idle_n) |->
    $stable(pins.addr) && $stable(pins.read_not_write_n) && $stable(pins.lane_select_outputs))
    else $error("bus outputs moved while idle");
  AST_STALL_HOLD: assert property (dc_q && !stall_request_n |=> $stable(pins) && $stable(data_oe))
    else $error("outputs moved during stall");
  AST_LOCK_RISE: assert property ($rose(pins.lock) |-> !pins.read_not_write_n && !pins.cycle_type_idle_n && !dc_q)
    else $error("lock rose off a read start");
  AST_LOCK_SPAN: assert property ($rose(pins.lock) |-> pins.lock[*4] ##[1:16] !pins.lock)
    else $error("lock span wrong");
  AST_FILL_FLAG: assert property (dc_q && !pins.read_not_write_n && !pins.cycle_type_idle_n |-> pins.line_fill_flag)
    else $error("read burst without fill flag");
  AST_BURST_LEN: assert property (dc_q && stall_request_n && pins.cycle_type_idle_n && pins.line_fill_flag
    |-> wc_q == 4'h7) else $error("flagged burst not eight words");
  AST_BURST_BLOCK: assert property (dc_q && stall_request_n && !pins.cycle_type_idle_n |=>
    pins.addr[31:5] == $past(pins.addr[31:5]) && $stable(pins.read_not_write_n))
    else $error("burst left its block or turned");
  AST_WR_STEP: assert property (dc_q && stall_request_n && !pins.cycle_type_idle_n && pins.read_not_write_n
    |=> pins.addr[4:2] == $past(pins.addr[4:2]) + 3'h1) else $error("write burst step wrong");
  AST_DRIVE_WIN: assert property (data_oe == (dc_q && pins.read_not_write_n))
    else $error("data drive outside write cycle");

  // main scenarios reached
  cover property (dc_q && !stall_request_n);
  cover property ($rose(pins.lock));
  cover property (dc_q && pins.line_fill_flag && pins.read_not_write_n);
endmodule : cmbt_bus_props

bind cmbt_bus_engine cmbt_bus_props u_props (.clk(clk), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .pins(pins), .data_o(data_o), .data_oe(data_oe), .data_i(data_i), .stall_request_n(stall_request_n));

`default_nettype wire

/* File: verification/cmbt_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none

module cmbt_mem_model (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // memory bus
  input  wire cmbt_pkg::cmbt_pins_t pins,
  input  wire logic                 stall_en,
  output logic                      stall_request_n,
  output logic [31:0]               data_i,
  output logic                      data_cyc
);
  logic        st_q;
  logic [31:0] alt_q;

  // data cycle tracking, single random stalls, changing filler
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_cyc <= 1'b0;
      st_q     <= 1'b1;
      alt_q    <= 32'h0;
    end else begin
      data_cyc <= !pins.cycle_type_idle_n || (data_cyc && !stall_request_n);
      st_q     <= !(stall_en && st_q && $urandom_range(3) == 0);
      alt_q    <= ~alt_q;
    end
  end

  // stall only in data cycles; word by address, masks never awaited
  assign stall_request_n = st_q || !data_cyc;
  assign data_i = (data_cyc && !pins.read_not_write_n) ? {pins.addr[31:2], 2'h0} ^ 32'h5a00_0000 : alt_q;
endmodule : cmbt_mem_model

`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic                    clk, nrst, stall_en, oe, sn, dcyc, er, lk;
  cmbt_pkg::cmbt_apb_req_t req;
  cmbt_pkg::cmbt_apb_rsp_t rsp;
  cmbt_pkg::cmbt_pins_t    pins;
  logic [31:0]             d_o, d_i, rd, wd, a, ba, x;
  logic [31:0]             wa [16];
  logic [5:0]              ms;
  int                      n_mismatch, n_tests, nw, n0, o;

  cmbt_bus_engine dut (.clk(clk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp), .pins(pins), .data_o(d_o),
    .data_oe(oe), .data_i(d_i), .stall_request_n(sn));
  cmbt_mem_model mem (.clk(clk), .nrst(nrst), .pins(pins), .stall_en(stall_en), .stall_request_n(sn),
    .data_i(d_i), .data_cyc(dcyc));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // monitor: data word addresses, written data, lock seen
  always @(posedge clk) begin
    if (dcyc && sn) begin
      wa[nw % 16] = pins.addr;
      ms = {pins.addr[1:0], pins.access_size_pins, pins.lane_select_outputs};
      if (pins.read_not_write_n) wd = d_o;
      nw++;
    end
    if (pins.lock) lk = 1'b1;
  end

  function automatic logic [31:0] word_of(input logic [31:0] ad);
    return {ad[31:2], 2'h0} ^ 32'h5a00_0000;
  endfunction : word_of

  function automatic logic [31:0] cmd(input logic [2:0] k, input int lm1, input logic c, input logic ab);
    return {18'h0, ab, c, 2'h0, cmbt_pkg::SIZE_WORD, 1'b0, lm1[2:0], 1'b0, k};
  endfunction : cmd

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, ad, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask : apb

  task automatic run(input logic m, input logic [31:0] ad, input logic [31:0] c, input int en, input logic [31:0] ea);
    apb(1'b1, 32'(cmbt_pkg::OFS_CTRL), {31'h0, m});
    apb(1'b1, 32'(cmbt_pkg::OFS_ADDR), ad);
    n0 = nw;
    lk = 1'b0;
    apb(1'b1, 32'(cmbt_pkg::OFS_CMD), c);
    for (int i = 0; i < 60; i++) begin
      apb(1'b0, 32'(cmbt_pkg::OFS_STAT), 32'h0);
      if (rd[0] === 1'b0) break;
    end
    chk(rd[0] === 1'b0 && nw - n0 == en, "busy or word count");
    if (en > 0) chk(wa[n0 % 16][31:2] === ea[31:2], "first address");
    if (en > 0) chk(ms === (m ? 6'h00 : {2'h0, cmbt_pkg::SIZE_WORD, 2'h0}), "size and lane pins");
  endtask : run

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  // main sequence
  initial begin
    nrst = 1'b0;
    stall_en = 1'b0;
    req = '0;
    nw = 0;
    lk = 1'b0;
    void'($urandom(32'h60483d70));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, 32'(cmbt_pkg::OFS_MASK), 32'h0);
    chk(rd === cmbt_pkg::MASK_RST, "mask reset value");
    apb(1'b0, 32'h44, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped access");
    stall_en <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      a = $urandom & 32'h0fff_fffc;
      x = $urandom;
      run(i[0], a, cmd(cmbt_pkg::K_RD, 0, 1'b0, 1'b0), 1, a);
      apb(1'b0, 32'h20, 32'h0);
      chk(rd === word_of(a), "single read data");
      run(i[0], a, cmd(cmbt_pkg::K_XLAT, 0, 1'b0, 1'b0), 1, a);
      run(i[0], a, cmd(cmbt_pkg::K_FILL, 0, 1'b0, 1'b0), 8, i[0] ? a : {a[31:5], 5'h0});
      for (int w = 0; w < 8; w++) begin
        apb(1'b0, 32'h20 + 32'(4 * w), 32'h0);
        chk(rd === word_of({a[31:5], w[2:0], 2'h0}), "fill word");
      end
      apb(1'b1, 32'h20, x);
      run(i[0], a, cmd(cmbt_pkg::K_WR, 0, 1'b0, 1'b0), 1, a);
      chk(wd === x, "unbuffered write data");
      apb(1'b1, 32'h24, ~x);
      run(i[0], a, cmd(cmbt_pkg::K_SWAP, 0, 1'b0, 1'b0), 2, a);
      chk(lk === 1'b1 && wd === ~x, "locked swap");
      run(i[0], a, cmd(cmbt_pkg::K_SWAP, 0, 1'b1, 1'b0), 0, a);
      run(i[0], a, cmd(cmbt_pkg::K_SWAP, 0, 1'b1, 1'b1), 8, i[0] ? a : {a[31:5], 5'h0});
      chk(lk === 1'b0, "cached swap unlocked");
      apb(1'b1, 32'(cmbt_pkg::OFS_MASK), 32'hffff_fff0);
      run(1'b1, {a[31:5], 5'h0}, cmd(cmbt_pkg::K_WBST, 3, 1'b0, 1'b0), 0, a);
      chk(rd[2] === 1'b1, "empty end word refused");
      apb(1'b1, 32'(cmbt_pkg::OFS_MASK), 32'hffff_ffff);
      // one legal start per burst length
      for (int k = 0; k < 4; k++) begin
        automatic int len = (k == 3) ? 8 : k + 2;
        do o = $urandom % 8; while (len == 2 ? o % 4 == 3 : (len == 3 ? o % 4 > 1 : (len == 4 ? o % 4 != 0 : o != 0)));
        ba = {a[31:5], o[2:0], 2'h0};
        run(i[0], ba, cmd(cmbt_pkg::K_WBST, len - 1, 1'b0, 1'b0), len, ba);
      end
      run(1'b0, {a[31:5], 5'hc}, cmd(cmbt_pkg::K_WBST, 1, 1'b0, 1'b0), 0, a);
      chk(rd[2] === 1'b1, "illegal start refused");
    end
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
